// File: tb/sep_master.sv
// serial bus master model driving the command port
`timescale 1ns/1ps
module sep_master (
   input  wire logic            clk,
   input  wire logic            serial_out,
   input  wire logic            serial_out_en,
   output sep_pkg::sep_pins_type pins
);
   // ------------------------------------------------------------
   // line model and frame tasks
   // ------------------------------------------------------------
   logic so_last = 1'h0;
   // a released output line floats: show a changing level
   wire  so_line = serial_out_en ? serial_out : ~so_last;
   always @(posedge clk) so_last <= so_line;
   initial pins = '0;
   task automatic bit_io(input logic b, output logic q);
      pins.serial_in = b;
      repeat (2) @(negedge clk);
      pins.sclk = 1'h1;
      repeat (3) @(negedge clk);
      q = so_line;
      pins.sclk = 1'h0;
   endtask
   task automatic frame(input logic [31:0] v, input int n, input int nrd,
         output logic dm, output logic [15:0] rd);
      logic q;
      rd = 16'h0000;
      pins.select = 1'h1;
      @(negedge clk);
      for (int i = n - 1; i >= 0; i--) bit_io(v[i], q);
      dm = q;
      for (int i = 0; i < nrd; i++) begin
         bit_io(1'h0, q);
         rd = {rd[14:0], q};
      end
      pins.select = 1'h0;
      pins.serial_in = ~pins.serial_in;
      repeat (3) @(negedge clk);
   endtask
   task automatic sel(input logic s);
      pins.select = s;
      repeat (3) @(negedge clk);
   endtask
endmodule

// File: tb/sep_port_checker.sv
// assertions on the pins of the serial eeprom command port
`timescale 1ns/1ps
module sep_port_checker #(
   parameter int unsigned WORD_CYCLES = 20,
   parameter int unsigned ALL_CYCLES  = 50
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic org16,
   input wire logic select,
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_en,
   input wire logic prog_busy
);
   // ------------------------------------------------------------
   // program cycle length counter and properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   int unsigned busy_cnt_r;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) busy_cnt_r <= 0;
      else busy_cnt_r <= prog_busy ? busy_cnt_r + 1 : 0;
   end
   property p_release; !select |-> !serial_out_en; endproperty
   a_release: assert property (p_release) else $error("driven while deselected");
   property p_busy_low; serial_out_en && prog_busy |-> !serial_out; endproperty
   a_busy_low: assert property (p_busy_low) else $error("busy flag not low");
   property p_ready; serial_out_en && $fell(prog_busy) |-> serial_out; endproperty
   a_ready: assert property (p_ready) else $error("ready flag not high");
   property p_status_on; $rose(select) && prog_busy |-> ##[1:3] serial_out_en; endproperty
   a_status_on: assert property (p_status_on) else $error("status not shown");
   property p_prog_start; $rose(prog_busy) |-> !select; endproperty
   a_prog_start: assert property (p_prog_start) else $error("program while selected");
   property p_prog_len;
      $fell(prog_busy) |-> (busy_cnt_r + 1 >= WORD_CYCLES && busy_cnt_r <= WORD_CYCLES + 4)
         || (busy_cnt_r + 1 >= ALL_CYCLES && busy_cnt_r <= ALL_CYCLES + 4);
   endproperty
   a_prog_len: assert property (p_prog_len) else $error("program length wrong");
   property p_shift;
      serial_out_en && $past(serial_out_en) && !$past(prog_busy) && $changed(serial_out)
         |-> $past(sclk);
   endproperty
   a_shift: assert property (p_shift) else $error("output moved off clock rise");
   property p_en_cause; $rose(serial_out_en) |-> prog_busy || sclk; endproperty
   a_en_cause: assert property (p_en_cause) else $error("output enabled uncaused");
   property p_dummy; $rose(serial_out_en) && !prog_busy |-> !serial_out; endproperty
   a_dummy: assert property (p_dummy) else $error("no leading zero");
endmodule

bind sep_port sep_port_checker #(.WORD_CYCLES(WORD_CYCLES), .ALL_CYCLES(ALL_CYCLES)) i_chk (
   .clk(clk), .nrst(nrst), .org16(org16), .select(select), .sclk(sclk),
   .serial_in(serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
   .prog_busy(prog_busy));

// File: tb/serial_eeprom_command_port_tb_top.sv
// self-checking bench for the serial eeprom command port
`timescale 1ns/1ps
`include "sep_consts.svh"
module serial_eeprom_command_port_tb_top;
   // ------------------------------------------------------------
   // setup
   // ------------------------------------------------------------
   localparam int unsigned WC = 20;
   localparam int unsigned AC = 50;
   logic                  clk = 1'h0;
   logic                  nrst = 1'h0;
   logic                  org16 = 1'h0;
   logic                  serial_out;
   logic                  serial_out_en;
   logic                  prog_busy;
   logic                  en_m;
   sep_pkg::sep_pins_type pins;
   logic [15:0]           mem [128];
   int                    n_fail = 0;
   int                    n_checks = 0;
   int                    cycles = 0;
   int                    seed = 80421;
   always #4 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         n_fail++;
         finish_test();
      end
   end
   sep_port #(.WORD_CYCLES(WC), .ALL_CYCLES(AC)) i_dut (
      .clk(clk), .nrst(nrst), .org16(org16), .select(pins.select), .sclk(pins.sclk),
      .serial_in(pins.serial_in), .serial_out(serial_out), .serial_out_en(serial_out_en),
      .prog_busy(prog_busy));
   sep_master i_mst (.clk(clk), .serial_out(serial_out), .serial_out_en(serial_out_en),
      .pins(pins));
   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   function automatic logic [6:0] sub(input logic [1:0] s);
      logic [6:0] r;
      r = $random(seed);
      return org16 ? {1'h0, s, r[3:0]} : {s, r[4:0]};
   endfunction
   task automatic cmd(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
         input int lead, input int drop, input int nrd, output logic dm, output logic [15:0] rd);
      int          aw;
      int          dw;
      int          n;
      logic [31:0] v;
      aw = org16 ? 6 : 7;
      dw = org16 ? 16 : 8;
      v = 32'({1'h1, op});
      v = (v << aw) | (32'(a) & ((32'h1 << aw) - 32'h1));
      n = 3 + aw;
      if (op == `SEP_OP_WRITE || (op == `SEP_OP_SPECIAL && sub_of(a) == `SEP_SUB_WRALL)) begin
         v = (v << dw) | (32'(d) & ((32'h1 << dw) - 32'h1));
         n = n + dw;
      end
      v = v >> drop;
      i_mst.frame(v, n - drop + lead, nrd, dm, rd);
   endtask
   function automatic logic [1:0] sub_of(input logic [6:0] a);
      return org16 ? a[5:4] : a[6:5];
   endfunction
   task automatic run(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d,
         input logic poll, input int drop, input int ext);
      logic        dm;
      logic [15:0] rd;
      logic [1:0]  s;
      logic        pr;
      logic [6:0]  ix;
      s = sub_of(a);
      ix = org16 ? {1'h0, a[5:0]} : a;
      pr = op != `SEP_OP_READ && !(op == `SEP_OP_SPECIAL && s[1] == s[0]) && drop == 0;
      cmd(op, a, d, {$random(seed)} % 4, drop, ext, dm, rd);
      if (op == `SEP_OP_SPECIAL && s[1] == s[0]) en_m = s[0];
      check(prog_busy, pr & en_m, "program start");
      if (pr & en_m) begin
         if (op == `SEP_OP_WRITE) mem[ix] = d;
         else if (op == `SEP_OP_ERASE) mem[ix] = `SEP_ERASED;
         else for (int i = 0; i < 128; i++) mem[i] = s[0] ? d : `SEP_ERASED;
         if (poll) i_mst.sel(1'h1);
         check(serial_out_en, poll, "status drive");
         check(poll ? serial_out : serial_out_en, 1'h0, "busy flag");
         for (int t = 0; t < 80 && prog_busy === 1'h1; t++) begin
            @(negedge clk);
            if (!poll && serial_out_en !== 1'h0) check(serial_out_en, 1'h0, "released");
         end
         check(prog_busy, 1'h0, "cycle end");
         check(poll ? serial_out : !serial_out_en, 1'h1, "ready flag");
         if (poll) i_mst.sel(1'h0);
      end
   endtask
   task automatic rd_chk(input logic [6:0] a, input int nw);
      logic        dm;
      logic [15:0] rd;
      logic [15:0] ex;
      logic [6:0]  ix;
      ix = org16 ? {1'h0, a[5:0]} : a;
      ex = org16 ? mem[ix] : {8'h00, mem[ix][7:0]};
      if (nw == 2) ex = {mem[ix][7:0], mem[ix + 7'h1][7:0]};
      cmd(`SEP_OP_READ, a, 16'h0000, {$random(seed)} % 4, 0, nw * (org16 ? 16 : 8), dm, rd);
      check(dm, 1'h0, "dummy bit");
      check(rd, ex, "read data");
   endtask
   // ------------------------------------------------------------
   // sequence, once per organisation
   // ------------------------------------------------------------
   initial begin
      logic [6:0]  a;
      logic [15:0] d;
      for (int m = 0; m < 2; m++) begin
         nrst = 1'h0;
         org16 = m[0];
         en_m = 1'h0;
         repeat (16) @(negedge clk);
         nrst = 1'h1;
         repeat (4) @(negedge clk);
         check({prog_busy, serial_out_en}, 2'h0, "idle after reset");
         run(`SEP_OP_WRITE, 7'h05, 16'h1234, 1'h0, 0, 0);
         run(`SEP_OP_SPECIAL, sub(`SEP_SUB_ENABLE), 16'h0000, 1'h0, 0, 0);
         run(`SEP_OP_SPECIAL, sub(`SEP_SUB_ERALL), 16'h0000, 1'h1, 0, 0);
         rd_chk(7'h05, 1);
         for (int i = 0; i < 6; i++) begin
            a = $random(seed);
            d = $random(seed);
            run(`SEP_OP_WRITE, a, d, a[0], 0, i % 3);
            rd_chk(a, 1);
         end
         run(`SEP_OP_ERASE, a, 16'h0000, 1'h1, 0, 0);
         rd_chk(a, 1);
         a = m[0] ? 7'h3f : 7'h7f;
         run(`SEP_OP_WRITE, a, 16'hc35a, 1'h0, 0, 0);
         run(`SEP_OP_WRITE, 7'h00, 16'h5ac3, 1'h1, 0, 0);
         rd_chk(a, 2 - m);
         run(`SEP_OP_WRITE, a, 16'h0ff0, 1'h0, 1, 0);
         rd_chk(a, 1);
         run(`SEP_OP_SPECIAL, sub(`SEP_SUB_DISABLE), 16'h0000, 1'h0, 0, 0);
         run(`SEP_OP_WRITE, a, 16'h1111, 1'h1, 0, 0);
         rd_chk(a, 1);
         run(`SEP_OP_SPECIAL, sub(`SEP_SUB_ENABLE), 16'h0000, 1'h0, 0, 0);
         run(`SEP_OP_SPECIAL, sub(`SEP_SUB_WRALL), 16'ha55a, 1'h0, 0, 0);
         rd_chk(a, 1);
      end
      finish_test();
   end
endmodule

// File: verilog/sep_consts.svh
// constants for the serial eeprom command port
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH

`define SEP_OP_SPECIAL   2'h0
`define SEP_OP_WRITE     2'h1
`define SEP_OP_READ      2'h2
`define SEP_OP_ERASE     2'h3
`define SEP_SUB_DISABLE  2'h0
`define SEP_SUB_WRALL    2'h1
`define SEP_SUB_ERALL    2'h2
`define SEP_SUB_ENABLE   2'h3
`define SEP_ADDR_W8      7
`define SEP_ADDR_W16     6
`define SEP_DATA_W8      8
`define SEP_DATA_W16     16
`define SEP_HDR_BITS     2
`define SEP_WORDS        128
`define SEP_CLK_MHZ      125
`define SEP_T_WORD_MS    6
`define SEP_T_ALL_MS     15
`define SEP_ERASED       16'hffff

`endif

// File: verilog/sep_edge.sv
// edge detector for the serial clock and select lines
`timescale 1ns/1ps
module sep_edge (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic sig,
   output logic      rise,
   output logic      fall
);
   logic prev_r;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= sig;
      end
   end

   assign rise = sig & ~prev_r;
   assign fall = ~sig & prev_r;
endmodule

// File: verilog/sep_pkg.sv
// types for the serial eeprom command port
package sep_pkg;

   typedef enum logic [2:0] {
      SEP_IDLE  = 3'b000,
      SEP_HDR   = 3'b001,
      SEP_ADDR  = 3'b010,
      SEP_DATA  = 3'b011,
      SEP_READ  = 3'b100,
      SEP_DONE  = 3'b101
   } sep_state_type;

   typedef enum logic [2:0] {
      SEP_PRG_NONE  = 3'b000,
      SEP_PRG_ERASE = 3'b001,
      SEP_PRG_ERALL = 3'b010,
      SEP_PRG_WRITE = 3'b011,
      SEP_PRG_WRALL = 3'b100
   } sep_prog_type;

   // one program job handed to the timer and array
   typedef struct packed {
      sep_prog_type kind;
      logic [6:0]   addr;
      logic [15:0]  data;
   } sep_job_type;

   // serial pins from the master, sampled on clk
   typedef struct packed {
      logic select;
      logic sclk;
      logic serial_in;
   } sep_pins_type;

endpackage

// File: verilog/sep_port.sv
// serial eeprom command port: decoder, array, status output
// Operation
// R1 - high select selects; program finishes regardless
// R2 - low select resets command logic
// R3 - sample and shift on serial clock rise
// R4 - master may stall clock anytime
// R5 - ignore clock before start bit
// R6 - start bit: first rise with input high
// R7 - execute only after full bit count
// R8 - after last bit, ignore until start
// R9 - program cycles need no serial clock
// R10 - decode opcode and msb-first address
// R11 - opcode zero uses top address bits
// R12 - master sends 10 or 18 clocks
// R13 - 16-bit mode: 9 or 25 clocks
// R14 - read shifts word msb first
// R15 - output released except read/status
// R16 - status low busy, high ready
// R17 - status hidden while select low
// R18 - power up disabled; enable gates programming
// R19 - dummy zero precedes read data
// R20 - read continues to next address
// R21 - program starts on select fall
// R22 - program durations are parameters
`timescale 1ns/1ps
`include "sep_consts.svh"
module sep_port #(
   parameter int unsigned WORD_CYCLES = `SEP_T_WORD_MS * `SEP_CLK_MHZ * 1000,
   parameter int unsigned ALL_CYCLES  = `SEP_T_ALL_MS * `SEP_CLK_MHZ * 1000
) (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic org16,
   input  wire logic select,
   input  wire logic sclk,
   input  wire logic serial_in,
   output logic      serial_out,
   output logic      serial_out_en,
   output logic      prog_busy
);
   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync_r;
   logic       rst_n;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ------------------------------------------------------------
   // pin edges
   // ------------------------------------------------------------
   sep_pkg::sep_pins_type pins;
   logic                  sclk_rise;
   logic                  sel_rise;
   logic                  sel_fall;

   assign pins = '{select: select, sclk: sclk, serial_in: serial_in};

   sep_edge u_sclk_edge (
      .clk   (clk),
      .rst_n (rst_n),
      .sig   (pins.sclk),
      .rise  (sclk_rise),
      .fall  ()
   );

   sep_edge u_sel_edge (
      .clk   (clk),
      .rst_n (rst_n),
      .sig   (pins.select),
      .rise  (sel_rise),
      .fall  (sel_fall)
   );

   // ------------------------------------------------------------
   // array and program state
   // ------------------------------------------------------------
   logic [15:0]           mem_r [`SEP_WORDS];
   logic                  enable_r;
   logic                  pend_r;
   logic                  status_r;
   sep_pkg::sep_job_type  job_r;
   sep_pkg::sep_job_type  job_nxt;
   logic                  job_load;
   logic                  tmr_busy;
   logic                  tmr_done;
   logic                  tmr_start;

   // ------------------------------------------------------------
   // command shifter
   // ------------------------------------------------------------
   sep_pkg::sep_state_type state_r;
   sep_pkg::sep_state_type state_nxt;
   logic [4:0]             cnt_r;
   logic [4:0]             cnt_nxt;
   logic [1:0]             op_r;
   logic [6:0]             addr_r;
   logic [15:0]            data_r;
   logic [15:0]            shout_r;
   logic                   dout_r;
   logic [4:0]             addr_len;
   logic [4:0]             data_len;
   logic [6:0]             addr_nxt;
   logic [6:0]             addr_mask;
   logic [1:0]             sub;
   logic                   active;
   logic                   step;

   // top two address bits form the opcode-zero sub-command
   function automatic logic [1:0] sub_of(input logic [6:0] a, input logic o16);
      sub_of = o16 ? a[5:4] : a[6:5];
   endfunction

   assign addr_len  = org16 ? 5'(`SEP_ADDR_W16) : 5'(`SEP_ADDR_W8);
   assign data_len  = org16 ? 5'(`SEP_DATA_W16) : 5'(`SEP_DATA_W8);
   assign addr_mask = org16 ? 7'h3f : 7'h7f;
   assign addr_nxt  = {addr_r[5:0], pins.serial_in} & addr_mask;           // [R10]
   assign sub       = sub_of(addr_r, org16);                               // [R11]
   assign active    = pins.select && !tmr_busy && !pend_r;
   assign step      = active && sclk_rise;                                 // [R3] [R5]

   function automatic logic [15:0] rd_word(input logic [15:0] w, input logic o16);
      rd_word = o16 ? w : {w[7:0], 8'h00};
   endfunction

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         sep_pkg::SEP_IDLE: begin
            if (pins.serial_in) begin                                      // [R6]
               state_nxt = sep_pkg::SEP_HDR;
               cnt_nxt   = 5'h0;
            end
         end
         sep_pkg::SEP_HDR: begin
            cnt_nxt = cnt_r + 5'h1;
            if (cnt_r == 5'(`SEP_HDR_BITS - 1)) begin
               state_nxt = sep_pkg::SEP_ADDR;
               cnt_nxt   = 5'h0;
            end
         end
         sep_pkg::SEP_ADDR: begin
            cnt_nxt = cnt_r + 5'h1;
            if (cnt_r == addr_len - 5'h1) begin                            // [R7]
               cnt_nxt = 5'h0;
               if (op_r == `SEP_OP_READ) begin
                  state_nxt = sep_pkg::SEP_READ;
               end else if (op_r == `SEP_OP_WRITE || (op_r == `SEP_OP_SPECIAL
                            && sub_of(addr_nxt, org16) == `SEP_SUB_WRALL)) begin
                  state_nxt = sep_pkg::SEP_DATA;
               end else begin
                  state_nxt = sep_pkg::SEP_DONE;
               end
            end
         end
         sep_pkg::SEP_DATA: begin
            cnt_nxt = cnt_r + 5'h1;
            if (cnt_r == data_len - 5'h1) begin                            // [R13]
               state_nxt = sep_pkg::SEP_DONE;
            end
         end
         sep_pkg::SEP_READ: begin
            cnt_nxt = (cnt_r == data_len - 5'h1) ? 5'h0 : cnt_r + 5'h1;    // [R20]
         end
         sep_pkg::SEP_DONE: begin
            state_nxt = sep_pkg::SEP_DONE;                                 // [R8]
         end
         default: begin
            state_nxt = sep_pkg::SEP_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= sep_pkg::SEP_IDLE;
         cnt_r   <= 5'h0;
      end else if (!pins.select) begin
         state_r <= sep_pkg::SEP_IDLE;                                     // [R2]
         cnt_r   <= 5'h0;
      end else if (step) begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         op_r   <= 2'h0;
         addr_r <= 7'h0;
         data_r <= 16'h0;
      end else if (step) begin
         if (state_r == sep_pkg::SEP_HDR) begin
            op_r <= {op_r[0], pins.serial_in};
         end
         if (state_r == sep_pkg::SEP_ADDR) begin
            addr_r <= addr_nxt;
         end
         if (state_r == sep_pkg::SEP_DATA) begin
            data_r <= {data_r[14:0], pins.serial_in};
         end
         if (state_r == sep_pkg::SEP_READ && cnt_r == data_len - 5'h1) begin
            addr_r <= (addr_r + 7'h1) & addr_mask;                         // [R20]
         end
      end
   end

   // ------------------------------------------------------------
   // read shifter and output driver
   // ------------------------------------------------------------
   logic last_addr;
   logic read_reload;

   assign last_addr   = state_r == sep_pkg::SEP_ADDR && cnt_r == addr_len - 5'h1;
   assign read_reload = state_r == sep_pkg::SEP_READ && cnt_r == data_len - 5'h1;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shout_r <= 16'h0;
         dout_r  <= 1'b0;
      end else if (step) begin
         if (last_addr && op_r == `SEP_OP_READ) begin
            shout_r <= rd_word(mem_r[addr_nxt], org16);
            dout_r  <= 1'b0;                                               // [R19]
         end else if (state_r == sep_pkg::SEP_READ) begin
            dout_r  <= shout_r[15];                                        // [R14]
            shout_r <= read_reload
                       ? rd_word(mem_r[(addr_r + 7'h1) & addr_mask], org16)
                       : {shout_r[14:0], 1'b0};
         end
      end
   end

   // status shows on each select rise while a program is still pending or running
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r <= 1'b0;
      end else if (sel_fall) begin
         status_r <= 1'b0;                                                 // [R15]
      end else if (sel_rise && (tmr_busy || pend_r)) begin
         status_r <= 1'b1;                                                 // [R16]
      end
   end

   assign serial_out_en = pins.select
                          && (state_r == sep_pkg::SEP_READ || status_r);   // [R15] [R17]
   assign serial_out    = status_r ? !(tmr_busy || pend_r) : dout_r;       // [R16]
   assign prog_busy     = tmr_busy || pend_r;                              // [R1]

   // ------------------------------------------------------------
   // execution on select fall
   // ------------------------------------------------------------
   logic cmd_done;

   assign cmd_done = state_r == sep_pkg::SEP_DONE;

   always_comb begin
      job_nxt  = '{kind: sep_pkg::SEP_PRG_NONE, addr: addr_r, data: data_r};
      job_load = 1'b0;
      if (sel_fall && cmd_done && enable_r) begin                          // [R21] [R18]
         job_load = 1'b1;
         unique case (op_r)
            `SEP_OP_ERASE:   job_nxt.kind = sep_pkg::SEP_PRG_ERASE;
            `SEP_OP_WRITE:   job_nxt.kind = sep_pkg::SEP_PRG_WRITE;
            `SEP_OP_SPECIAL: begin
               job_nxt.kind = (sub == `SEP_SUB_ERALL) ? sep_pkg::SEP_PRG_ERALL
                            : (sub == `SEP_SUB_WRALL) ? sep_pkg::SEP_PRG_WRALL
                            : sep_pkg::SEP_PRG_NONE;
               job_load     = (sub == `SEP_SUB_ERALL) || (sub == `SEP_SUB_WRALL);
            end
            `SEP_OP_READ:    job_load = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_r <= 1'b0;                                                 // [R18]
      end else if (sel_fall && cmd_done && op_r == `SEP_OP_SPECIAL) begin
         if (sub == `SEP_SUB_ENABLE) begin
            enable_r <= 1'b1;
         end else if (sub == `SEP_SUB_DISABLE) begin
            enable_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         job_r  <= '0;
         pend_r <= 1'b0;
      end else if (job_load) begin
         job_r  <= job_nxt;
         pend_r <= 1'b1;
      end else if (tmr_start) begin
         pend_r <= 1'b0;
      end
   end

   assign tmr_start = pend_r && !tmr_busy;

   sep_prog_timer #(
      .WORD_CYCLES (WORD_CYCLES),
      .ALL_CYCLES  (ALL_CYCLES)
   ) u_timer (
      .clk   (clk),
      .rst_n (rst_n),
      .start (tmr_start),
      .whole (job_r.kind == sep_pkg::SEP_PRG_ERALL || job_r.kind == sep_pkg::SEP_PRG_WRALL),
      .busy  (tmr_busy),
      .done  (tmr_done)
   );                                                                      // [R22] [R9]

   // array update at the end of the timed cycle; no serial clock needed
   logic [15:0] wr_val;

   assign wr_val = org16 ? job_r.data : {8'h00, job_r.data[7:0]};

   always_ff @(posedge clk) begin
      if (tmr_done) begin                                                  // [R9]
         for (int i = 0; i < `SEP_WORDS; i++) begin
            unique case (job_r.kind)
               sep_pkg::SEP_PRG_ERASE:
                  if (7'(i) == job_r.addr) mem_r[i] <= `SEP_ERASED;
               sep_pkg::SEP_PRG_WRITE:
                  if (7'(i) == job_r.addr) mem_r[i] <= wr_val;
               sep_pkg::SEP_PRG_ERALL:  mem_r[i] <= `SEP_ERASED;
               sep_pkg::SEP_PRG_WRALL:  mem_r[i] <= wr_val;
               sep_pkg::SEP_PRG_NONE:   mem_r[i] <= mem_r[i];
               default:                 mem_r[i] <= mem_r[i];
            endcase
         end
      end
   end
endmodule

// File: verilog/sep_prog_timer.sv
// self-timed program cycle timer
`timescale 1ns/1ps
`include "sep_consts.svh"
module sep_prog_timer #(
   parameter int unsigned WORD_CYCLES = `SEP_T_WORD_MS * `SEP_CLK_MHZ * 1000,
   parameter int unsigned ALL_CYCLES  = `SEP_T_ALL_MS * `SEP_CLK_MHZ * 1000
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic start,
   input  wire logic whole,
   output logic      busy,
   output logic      done
);
   logic [31:0] cnt_r;
   logic        busy_r;
   logic [31:0] load;
   logic        last;

   assign load = whole ? ALL_CYCLES : WORD_CYCLES;
   assign last = busy_r && (cnt_r <= 32'h1);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r  <= 32'h0;
         busy_r <= 1'b0;
      end else if (start && !busy_r) begin
         cnt_r  <= load;
         busy_r <= 1'b1;
      end else if (busy_r) begin
         cnt_r  <= cnt_r - 32'h1;
         busy_r <= !last;
      end
   end

   assign busy = busy_r;
   assign done = last;
endmodule
